// File: core/cmb_pkg.sv
// constants and carrier types shared by the clock-mode and boot-config block
// assumes one 50 MHz core clock; the mode, reference and boot width pins are synchronised inside the block, rst_n is not
package cmb_pkg;

   // ============================================================
   // clocking
   localparam int unsigned CLOCK_HZ    = 50_000_000;
   localparam int unsigned SYS_HZ      = 16_580_000;
   localparam int unsigned REF_SLOW_HZ = 32_768;
   localparam int unsigned REF_FAST_HZ = 38_400;
   localparam int unsigned NCO_W       = 24;
   // phase step giving SYS_HZ ticks on average out of CLOCK_HZ
   localparam logic [NCO_W-1:0] NCO_INC =
      NCO_W'((64'(SYS_HZ) << NCO_W) / 64'(CLOCK_HZ));
   localparam logic [3:0] LOCK_REF_EDGES = 4'h8;

   // ============================================================
   // reset and boot chip-select
   localparam int unsigned RESET_HOLD_MS = 100;
   localparam logic [3:0]  BOOT_WAIT_STATES = 4'h6;
   localparam int unsigned NUM_CS           = 16;
   localparam logic [3:0]  BOOT_CS_IDX      = 4'h0;

   // ============================================================
   // internal register space, never decoded by the boot chip-select
   localparam logic [31:0] INT_REG_BASE = 32'hfffff000;
   localparam logic [31:0] INT_REG_MASK = 32'hfffff000;

   typedef enum logic [1:0] {
      CMB_PLL_OFF     = 2'b00,
      CMB_PLL_LOCKING = 2'b01,
      CMB_PLL_LOCKED  = 2'b11,
      CMB_PLL_EXT     = 2'b10
   } cmb_pll_state_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [15:0] wdata;
   } cmb_core_req_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [15:0] data;
      logic        width16;
   } cmb_ext_cycle_t;

   typedef struct packed {
      logic       write;
      logic [3:0] idx;
      logic       width16;
      logic [3:0] waits;
      logic       enable;
   } cmb_cs_cfg_t;

   function automatic logic cmb_is_internal(input logic [31:0] addr);
      return (addr & INT_REG_MASK) == INT_REG_BASE;
   endfunction

endpackage

// File: core/cmb_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level; no multi-bit coherence is promised
module cmb_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clock,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   // no reset: a pin level settles on its own within two edges
   always_ff @(posedge clock) begin
      if (clkEn) begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// File: core/cmb_nco.sv
// phase accumulator that stands in for the synthesiser loop
// assumes the caller gates run until the reference has been seen
module cmb_nco #(
   parameter int unsigned      W   = 24,
   parameter logic [W-1:0]     INC = '0
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clkEn,
   input  wire logic run,
   output logic      tick
);
   logic [W-1:0] phase_q;
   logic [W:0]   sum;

   assign sum = {1'b0, phase_q} + {1'b0, INC};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_q <= '0;
         tick    <= 1'b0;
      end else if (clkEn) begin
         phase_q <= run ? sum[W-1:0] : '0;
         tick    <= run & sum[W];
      end
   end
endmodule

// File: core/clock_mode_and_boot_config.sv
// clock-mode selection, clock output, cold reset and boot chip-select setup
// assumes pins arrive asynchronously and the core bus is on this clock
//
// Contract
// - mode pin low enables the synthesiser, clocked from the low-rate reference.
// - synthesiser yields 16.58 MHz from a 32.768 kHz or 38.4 kHz reference.
// - mode pin high disables synthesiser; the reference input is the system clock.
// - mode pin may act as port bit only while the synthesiser is on.
// - system clock drives the clock output, which software may switch off.
// - reset input low puts the whole device into cold reset.
// - boot width pin low gives 8-bit boot region, high gives 16-bit.
// - core reads of internal registers never show on the external bus.
// - every core write shows as an external bus cycle.
// - software sets the data width of every other chip-select region.
// - after reset boot select is on, six waits, all but internal space.
module clock_mode_and_boot_config
   import cmb_pkg::*;
(
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic                     clkEn,
   input  wire logic                     clockModeSelectIn,
   output logic                          portCBit0Out,
   output logic                          portCBit0Oe_n,
   input  wire logic                     refClockIn,
   input  wire logic                     bootWidthSelect,
   input  wire logic                     portC0GpioReq,
   input  wire logic                     portC0Drive,
   input  wire logic                     portC0Data,
   output logic                          portC0Level,
   input  wire logic                     sysClockOutEn,
   output logic                          sysClockOut,
   output logic                          sysClockTick,
   output logic                          pllEnable,
   output logic                          pllLocked,
   output logic                          deviceReset_n,
   input  wire cmb_pkg::cmb_core_req_t   coreReq,
   output logic                          intRegSelect,
   output cmb_pkg::cmb_ext_cycle_t       extCycle,
   output logic                          bootChipSelect_n,
   input  wire cmb_pkg::cmb_cs_cfg_t     csCfg,
   output logic [3:0]                    bootCsWaits,
   output logic                          bootCsEnable,
   output logic [cmb_pkg::NUM_CS-1:0]    csWidth16
);
   import cmb_pkg::*;

   // ============================================================
   // state
   typedef struct packed {
      cmb_pll_state_t    pll;
      logic [3:0]        lockCnt;
      logic              refPrev;
      logic              gpio;
      logic              pinOut;
      logic              pinOe_n;
      logic              clkOut;
      logic              tick;
      logic              devRst_n;
      logic              bootWidth16;
      logic [3:0]        bootWaits;
      logic              bootEn;
      logic [NUM_CS-1:0] csWidth16;
      logic              intSel;
      logic              bootSel;
      cmb_ext_cycle_t    ext;
   } cmb_state_t;

   cmb_state_t s_q;
   cmb_state_t s_d;

   logic [2:0] pinsS;
   logic       modeS;
   logic       refS;
   logic       widthS;
   logic       refEdge;
   logic       ncoTick;
   logic       sysTick;
   logic       isInt;
   logic       showCycle;

   cmb_sync #(
      .W (3)
   ) u_sync (
      .clock   (clock),
      .clkEn   (clkEn),
      .async_i ({clockModeSelectIn, refClockIn, bootWidthSelect}),
      .sync_o  (pinsS)
   );

   assign modeS   = pinsS[2];
   assign refS    = pinsS[1];
   assign widthS  = pinsS[0];
   assign refEdge = refS & ~s_q.refPrev;

   // ============================================================
   // synthesiser model, runs only once reference edges are seen
   cmb_nco #(
      .W   (NCO_W),
      .INC (NCO_INC)
   ) u_nco (
      .clock (clock),
      .rst_n (rst_n),
      .clkEn (clkEn),
      .run   (s_q.pll == CMB_PLL_LOCKED),
      .tick  (ncoTick)
   );

   // in external mode the reference edge itself is the system clock tick
   always_comb begin
      unique case (s_q.pll)
         CMB_PLL_LOCKED: sysTick = ncoTick;
         CMB_PLL_EXT:    sysTick = refEdge;
         default:        sysTick = 1'b0;
      endcase
   end

   assign isInt     = cmb_is_internal(coreReq.addr);
   assign showCycle = coreReq.valid & (coreReq.write | ~isInt);

   // ============================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.refPrev  = refS;
      s_d.tick     = sysTick;
      s_d.devRst_n = 1'b1;

      // a pin repurposed as port bit no longer carries the mode: hold it
      unique case (s_q.pll)
         CMB_PLL_OFF: begin
            s_d.pll     = modeS ? CMB_PLL_EXT : CMB_PLL_LOCKING;
            s_d.lockCnt = '0;
         end
         CMB_PLL_LOCKING: begin
            if (modeS && !s_q.gpio) begin
               s_d.pll = CMB_PLL_EXT;
            end else if (refEdge) begin
               s_d.lockCnt = s_q.lockCnt + 4'h1;
               if (s_q.lockCnt == LOCK_REF_EDGES - 4'h1) begin
                  s_d.pll = CMB_PLL_LOCKED;
               end
            end
         end
         CMB_PLL_LOCKED: begin
            if (modeS && !s_q.gpio) begin
               s_d.pll = CMB_PLL_EXT;
            end
         end
         CMB_PLL_EXT: begin
            if (!modeS) begin
               s_d.pll     = CMB_PLL_LOCKING;
               s_d.lockCnt = '0;
            end
         end
      endcase

      // port bit granted only while the synthesiser stays on
      s_d.gpio    = portC0GpioReq && (s_d.pll inside {CMB_PLL_LOCKING, CMB_PLL_LOCKED});
      s_d.pinOut  = portC0Data;
      s_d.pinOe_n = !(s_d.gpio && portC0Drive);

      // output held low when switched off so no edge leaks out
      if (!sysClockOutEn) begin
         s_d.clkOut = 1'b0;
      end else if (sysTick) begin
         s_d.clkOut = ~s_q.clkOut;
      end

      if (csCfg.write) begin
         if (csCfg.idx == BOOT_CS_IDX) begin
            s_d.bootWidth16 = csCfg.width16;
            s_d.bootWaits   = csCfg.waits;
            s_d.bootEn      = csCfg.enable;
         end else begin
            s_d.csWidth16[csCfg.idx] = csCfg.width16;
         end
      end

      s_d.intSel      = coreReq.valid & isInt;
      s_d.bootSel     = showCycle & ~isInt & s_q.bootEn;
      s_d.ext.valid   = showCycle;
      s_d.ext.write   = coreReq.write;
      s_d.ext.addr    = coreReq.addr;
      s_d.ext.data    = coreReq.wdata;
      s_d.ext.width16 = s_q.bootWidth16;

      // cold reset: everything to its defaults, width pin sampled meanwhile
      if (!rst_n) begin
         s_d             = '0;
         s_d.pll         = CMB_PLL_OFF;
         // track the reference through reset so release shows no false edge
         s_d.refPrev     = refS;
         s_d.pinOe_n     = 1'b1;
         s_d.devRst_n    = 1'b0;
         s_d.bootWidth16 = widthS;
         s_d.bootWaits   = BOOT_WAIT_STATES;
         s_d.bootEn      = 1'b1;
      end
   end

   // reset acts even while the clock enable is low
   always_ff @(posedge clock) begin
      if (!rst_n || clkEn) begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // outputs
   assign portCBit0Out     = s_q.pinOut;
   assign portCBit0Oe_n    = s_q.pinOe_n;
   assign portC0Level      = modeS;
   assign sysClockOut      = s_q.clkOut;
   assign sysClockTick     = s_q.tick;
   assign pllEnable        = s_q.pll inside {CMB_PLL_LOCKING, CMB_PLL_LOCKED};
   assign pllLocked        = s_q.pll == CMB_PLL_LOCKED;
   assign deviceReset_n    = s_q.devRst_n;
   assign intRegSelect     = s_q.intSel;
   assign extCycle         = s_q.ext;
   assign bootChipSelect_n = ~s_q.bootSel;
   assign bootCsWaits      = s_q.bootWaits;
   assign bootCsEnable     = s_q.bootEn;
   assign csWidth16        = {s_q.csWidth16[NUM_CS-1:1], s_q.bootWidth16};

   // ============================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_core_read_int;
      clkEn && coreReq.valid && !coreReq.write && cmb_is_internal(coreReq.addr);
   endsequence

   sequence s_core_write;
      clkEn && coreReq.valid && coreReq.write;
   endsequence

   sequence s_cfg_other;
      clkEn && csCfg.write && csCfg.idx != BOOT_CS_IDX;
   endsequence

   property p_pll_on;
      clkEn && s_q.pll == CMB_PLL_EXT && !modeS |=> pllEnable && !pllLocked;
   endproperty
   a_pll_on: assert property (p_pll_on)
      else $error("synthesiser not enabled on mode low");

   property p_synth_tick;
      clkEn && pllLocked && sysClockTick |=> !sysClockTick;
   endproperty
   a_synth_tick: assert property (p_synth_tick)
      else $error("synthesiser ticks back to back");

   property p_ext_mode;
      clkEn && modeS && !s_q.gpio && pllEnable |=> !pllEnable ##0 sysTick == refEdge;
   endproperty
   a_ext_mode: assert property (p_ext_mode)
      else $error("external mode not entered");

   property p_gpio_needs_pll;
      !portCBit0Oe_n |-> pllEnable;
   endproperty
   a_gpio_needs_pll: assert property (p_gpio_needs_pll)
      else $error("port bit driven without pll");

   property p_clkout_off;
      clkEn && !sysClockOutEn |=> !sysClockOut;
   endproperty
   a_clkout_off: assert property (p_clkout_off)
      else $error("clock output not switched off");

   property p_cold_reset;
      disable iff (1'b0)
      !rst_n |=> !deviceReset_n && !extCycle.valid && bootChipSelect_n;
   endproperty
   a_cold_reset: assert property (p_cold_reset)
      else $error("cold reset not applied");

   property p_boot_width_caught;
      $rose(rst_n) |-> csWidth16[0] == $past(widthS) && extCycle.width16 == 1'b0;
   endproperty
   a_boot_width_caught: assert property (p_boot_width_caught)
      else $error("boot width not caught");

   property p_boot_width_used;
      !bootChipSelect_n |-> extCycle.width16 == $past(csWidth16[0]);
   endproperty
   a_boot_width_used: assert property (p_boot_width_used)
      else $error("boot width mismatch");

   property p_read_hidden;
      s_core_read_int |=> !extCycle.valid && intRegSelect;
   endproperty
   a_read_hidden: assert property (p_read_hidden)
      else $error("internal read shown on bus");

   property p_write_shown;
      s_core_write |=> extCycle.valid && extCycle.write && extCycle.addr == $past(coreReq.addr);
   endproperty
   a_write_shown: assert property (p_write_shown)
      else $error("core write not shown on bus");

   property p_cs_width;
      s_cfg_other |=> csWidth16[$past(csCfg.idx)] == $past(csCfg.width16);
   endproperty
   a_cs_width: assert property (p_cs_width)
      else $error("region width not programmed");

   property p_boot_default;
      $rose(rst_n) |-> bootCsWaits == BOOT_WAIT_STATES && bootCsEnable;
   endproperty
   a_boot_default: assert property (p_boot_default)
      else $error("boot select defaults wrong");

endmodule

// File: tb/cmb_board.sv
// board-side reference oscillator driving the reference clock pin
// assumes the bench says when the oscillator runs; it idles low when stopped
module cmb_board #(
   parameter int unsigned HALF_NS = 13021
) (
   input  wire logic run,
   output logic      refClock
);
   timeunit 1ns;
   timeprecision 1ns;
   // ============================================================
   // oscillator
   // 38.4 kHz; the same slow clock serves in external mode, where it must stay slow
   initial refClock = 1'b0;
   always begin
      #(HALF_NS);
      refClock = run ? ~refClock : 1'b0;
   end
endmodule

// File: tb/tb_clock_mode_and_boot_config.sv
// self-checking bench for the clock-mode and boot-config block
// assumes the package from core/ and the board oscillator model
module tb_clock_mode_and_boot_config;
   timeunit 1ns;
   timeprecision 1ns;
   import cmb_pkg::*;
   logic           clock, rst_n, modeSel, widthSel, gpioReq, gpioDrive, gpioData;
   logic           clkOutEn, oscRun, oe_n, pOut, pLvl, clkOut, tick, pllEn, pllLk;
   logic           devRst_n, intSel, bootCs_n, csEn, bootW, clkEn;
   logic [3:0]     csWaits;
   logic [15:0]    csW16;
   wire            refClk;
   cmb_core_req_t  coreReq;
   cmb_ext_cycle_t extCycle;
   cmb_cs_cfg_t    csCfg;
   int             errors, compares, cycles, nTick, nOut;

   cmb_board u_cmb_board (.run(oscRun), .refClock(refClk));
   clock_mode_and_boot_config u_clock_mode_and_boot_config (
      .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .clockModeSelectIn(modeSel),
      .portCBit0Out(pOut), .portCBit0Oe_n(oe_n), .refClockIn(refClk),
      .bootWidthSelect(widthSel), .portC0GpioReq(gpioReq), .portC0Drive(gpioDrive),
      .portC0Data(gpioData), .portC0Level(pLvl), .sysClockOutEn(clkOutEn),
      .sysClockOut(clkOut), .sysClockTick(tick), .pllEnable(pllEn), .pllLocked(pllLk),
      .deviceReset_n(devRst_n), .coreReq(coreReq), .intRegSelect(intSel),
      .extCycle(extCycle), .bootChipSelect_n(bootCs_n), .csCfg(csCfg),
      .bootCsWaits(csWaits), .bootCsEnable(csEn), .csWidth16(csW16));

   // ============================================================
   // clock, timeout, reporting
   initial clock = 1'b0;
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ============================================================
   // drivers
   task automatic core(input logic wr, input logic [31:0] a);
      @(posedge clock) coreReq <= '{1'b1, wr, a, 16'h5a3c};
      @(posedge clock) coreReq.valid <= 1'b0;
      #1;
   endtask
   task automatic cfg(input logic [3:0] i, input logic w, input logic [3:0] ws,
                      input logic en);
      @(posedge clock) csCfg <= '{1'b1, i, w, ws, en};
      @(posedge clock) csCfg.write <= 1'b0;
      #1;
   endtask
   task automatic count(input int n);
      logic prev;
      nTick = 0;
      nOut = 0;
      prev = clkOut;
      repeat (n) begin
         @(posedge clock) #1;
         if (tick === 1'b1) nTick++;
         if (clkOut === 1'b1 && prev === 1'b0) nOut++;
         prev = clkOut;
      end
   endtask

   // ============================================================
   // scenarios
   // reset is held 17 cycles here; the board's 100 ms is shortened
   task automatic do_reset(input logic w);
      bootW = w;
      @(posedge clock) begin
         widthSel <= w;
         rst_n <= 1'b0;
      end
      repeat (16) @(posedge clock);
      #1;
      check(devRst_n, 1'b0);
      check(extCycle.valid, 1'b0);
      @(posedge clock) rst_n <= 1'b1;
      @(posedge clock) widthSel <= ~w;
      #1;
      check(devRst_n, 1'b1);
      check(csWaits, BOOT_WAIT_STATES);
      check(csEn, 1'b1);
      repeat (5) @(posedge clock);
      #1;
      check(csW16, {15'h0, w});
   endtask
   task automatic test_bus();
      core(1'b1, 32'hfffff010);
      check(extCycle.valid, 1'b1);
      check(intSel, 1'b1);
      check(bootCs_n, 1'b1);
      core(1'b0, 32'hfffff000);
      check(extCycle.valid, 1'b0);
      core(1'b0, 32'hffffeffe);
      check({extCycle.valid, extCycle.addr}, {1'b1, 32'hffffeffe});
      check({bootCs_n, extCycle.width16}, {1'b0, bootW});
      core(1'b1, 32'h00400000);
      check({extCycle.valid, extCycle.write, extCycle.data}, {2'b11, 16'h5a3c});
   endtask
   // a config write while the enable is low must not land
   task automatic test_freeze();
      @(posedge clock) clkEn <= 1'b0;
      cfg(4'h5, 1'b1, 4'h0, 1'b0);
      @(posedge clock) clkEn <= 1'b1;
      #1;
      check(csW16[5], 1'b0);
   endtask
   task automatic test_cfg();
      cfg(4'h3, 1'b1, 4'h0, 1'b0);
      check(csW16, {12'h0, 1'b1, 2'b0, bootW});
      cfg(4'hf, 1'b1, 4'h0, 1'b0);
      check(csW16[15], 1'b1);
      cfg(4'h0, ~bootW, 4'h2, 1'b0);
      check({csWaits, csEn, csW16[0]}, {4'h2, 1'b0, ~bootW});
      core(1'b0, 32'h00001000);
      check({extCycle.valid, bootCs_n}, 2'b11);
   endtask
   task automatic test_pll();
      int t;
      for (t = 0; t < 20000 && pllLk !== 1'b1; t++) @(posedge clock) #1;
      check({pllEn, pllLk}, 2'b11);
      @(posedge clock) clkOutEn <= 1'b1;
      count(5000);
      check(nTick >= 1656 && nTick <= 1660, 1'b1);
      check(nOut >= nTick / 2 - 1 && nOut <= nTick / 2 + 1, 1'b1);
      @(posedge clock) clkOutEn <= 1'b0;
      repeat (2) @(posedge clock);
      count(200);
      check(nOut, 0);
      @(posedge clock) begin
         gpioReq <= 1'b1;
         gpioDrive <= 1'b1;
         gpioData <= 1'b1;
      end
      repeat (4) @(posedge clock);
      @(posedge clock) modeSel <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      check({oe_n, pOut, pllEn}, 3'b011);
      check(pLvl, 1'b1);
      @(posedge clock) gpioReq <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
      check({oe_n, pllEn, pllLk}, 3'b100);
   endtask
   task automatic test_ext();
      @(posedge clock) gpioReq <= 1'b1;
      count(5000);
      check(nTick >= 3 && nTick <= 4, 1'b1);
      check({oe_n, pllEn}, 2'b10);
      @(posedge clock) modeSel <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check({pllEn, pllLk}, 2'b10);
   endtask

   initial begin
      {rst_n, modeSel, widthSel, gpioReq, gpioDrive, gpioData, clkOutEn} = '0;
      oscRun = 1'b1;
      clkEn = 1'b1;
      coreReq = '0;
      csCfg = '0;
      do_reset(1'b0);
      do_reset(1'b1);
      test_bus();
      test_cfg();
      test_freeze();
      test_pll();
      test_ext();
      give_verdict();
   end
endmodule
